/* File: shared/mox_pkg.sv */
package mox_pkg;

  localparam int DATA_W = 8;
  localparam int PC_W   = 13;
  localparam int ADDR_W = 8;

  typedef logic [DATA_W-1:0] mox_byte_t;

  // Operation selector, one-hot.
  typedef enum logic [7:0] {
    OP_IDLE    = 8'h01,
    OP_OR_MEM  = 8'h02,
    OP_OR_IMM  = 8'h04,
    OP_OR_STO  = 8'h08,
    OP_RET     = 8'h10,
    OP_RET_IMM = 8'h20,
    OP_INTERRUPT_EXIT    = 8'h40,
    OP_ROL     = 8'h80
  } mox_op_t;

  // Execution phases, one-hot.
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } mox_state_t;

  // One instruction request from the decoder.
  typedef struct packed {
    mox_op_t            op;
    logic [ADDR_W-1:0]  addr;
    mox_byte_t          imm;
  } mox_req_t;

  // Data memory access bundle.
  typedef struct packed {
    logic               wr;
    logic [ADDR_W-1:0]  addr;
    mox_byte_t          wdata;
  } mox_mem_t;

  localparam logic [ADDR_W-1:0] ADDR_ZERO = 8'h00;
  localparam mox_byte_t         BYTE_ZERO = 8'h00;
  localparam logic [PC_W-1:0]   PC_ONE    = 13'h0001;
  localparam logic [PC_W-1:0]   PC_RESET  = 13'h0000;
  localparam logic [PC_W-1:0]   IRQ_VECT  = 13'h0004;
  localparam logic [3:0]        STK_DEPTH = 4'h8;

endpackage : mox_pkg

/* File: verilog/mox_dmem.sv */
`timescale 1ns/1ps
module mox_dmem (
  // Clock.
  input  wire logic              clk_i,
  // Access.
  input  wire mox_pkg::mox_mem_t mem_i,
  input  wire logic              we_i,
  output logic [7:0]             rdata_o
);

  // Contents start cleared so that the first merge or rotate sees a known byte.
  logic [7:0] mem [0:255] = '{default: mox_pkg::BYTE_ZERO};

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem[mem_i.addr] <= mem_i.wdata;
    end
    rdata_o <= mem[mem_i.addr];
  end

endmodule : mox_dmem

/* File: verilog/mox_exec.sv */
`timescale 1ns/1ps
//
// Function
// - Idle instruction only advances program counter.
// - OR memory into working_reg, update zero.
// - OR immediate into working_reg, update zero.
// - OR working_reg into memory, keep working_reg.
// - Subroutine exit pops program counter, flags kept.
// - Return pops counter and loads immediate.
// - Interrupt exit pops counter, sets enable.
// - Pending interrupt served before return address.
// - Rotate memory byte left, bit7 to bit0.
module mox_exec (
  // Clock and reset.
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  // Instruction request.
  input  wire logic              req_valid_i,
  input  wire mox_pkg::mox_req_t req_i,
  input  wire logic              irq_pending_i,
  // Stack push from the core (calls).
  input  wire logic              push_i,
  input  wire logic [12:0]       push_pc_i,
  // Status.
  output logic                   busy_o,
  output logic                   done_o,
  output logic [12:0]            pc_o,
  output logic [7:0]             working_reg_o,
  output logic                   result_null_flag_o,
  output logic                   global_interrupt_enable_o,
  output logic                   irq_taken_o
);

  //////////////////////////////////////////////////////////////////////////////

  mox_pkg::mox_state_t state, next_state;
  mox_pkg::mox_op_t    op, next_op;
  mox_pkg::mox_mem_t   mem, next_mem;
  logic                we, next_we;
  logic [7:0]          rdata;
  logic [12:0]         pc, next_pc;
  logic [7:0]          acc, next_acc;
  logic                zf, next_zf;
  logic                gie, next_gie;
  logic                done, next_done;
  logic                irqt, next_irqt;
  logic [12:0]         stk [0:7];
  logic [12:0]         next_stk [0:7];
  logic [3:0]          sp, next_sp;
  logic                busy, next_busy;
  logic [7:0]          res;
  logic [12:0]         top;

  mox_dmem u_dmem (
    .clk_i   (clk_i),
    .mem_i   (next_mem),
    .we_i    (next_we),
    .rdata_o (rdata)
  );

  //////////////////////////////////////////////////////////////////////////////

  always_comb begin
    next_state = state;
    next_op    = op;
    next_mem   = mem;
    next_we    = 1'b0;
    next_pc    = pc;
    next_acc   = acc;
    next_zf    = zf;
    next_gie   = gie;
    next_done  = 1'b0;
    next_irqt  = 1'b0;
    next_sp    = sp;
    for (int i = 0; i < 8; i++) begin
      next_stk[i] = stk[i];
    end
    top = stk[3'(sp - 4'h1)];
    res = 8'h00;
    if (push_i && sp < mox_pkg::STK_DEPTH) begin
      next_stk[sp[2:0]] = push_pc_i;
      next_sp           = sp + 4'h1;
    end
    case (state)
      mox_pkg::ST_IDLE: begin
        if (req_valid_i) begin
          next_op        = req_i.op;
          next_mem.addr  = req_i.addr;
          next_mem.wr    = 1'b0;
          next_done      = 1'b1;
          next_pc        = pc + mox_pkg::PC_ONE;
          case (req_i.op)
            mox_pkg::OP_IDLE: begin
              next_done = 1'b1;
            end
            mox_pkg::OP_OR_IMM: begin
              res      = acc | req_i.imm;
              next_acc = res;
              next_zf  = (res == mox_pkg::BYTE_ZERO);
            end
            mox_pkg::OP_RET, mox_pkg::OP_RET_IMM, mox_pkg::OP_INTERRUPT_EXIT: begin
              next_pc = top;
              next_sp = sp - 4'h1;
              if (req_i.op == mox_pkg::OP_RET_IMM) begin
                next_acc = req_i.imm;
              end
              if (req_i.op == mox_pkg::OP_INTERRUPT_EXIT) begin
                next_gie = 1'b1;
                if (irq_pending_i) begin
                  next_pc   = mox_pkg::IRQ_VECT;
                  next_sp   = sp;
                  next_gie  = 1'b0;
                  next_irqt = 1'b1;
                end
              end
            end
            mox_pkg::OP_OR_MEM, mox_pkg::OP_OR_STO, mox_pkg::OP_ROL: begin
              next_done  = 1'b0;
              next_state = mox_pkg::ST_READ;
            end
            default: begin
              next_done = 1'b1;
            end
          endcase
        end
      end
      mox_pkg::ST_READ: begin
        next_state = mox_pkg::ST_WRITE;
      end
      mox_pkg::ST_WRITE: begin
        next_state = mox_pkg::ST_IDLE;
        next_done  = 1'b1;
        case (op)
          mox_pkg::OP_OR_MEM: begin
            res      = acc | rdata;
            next_acc = res;
            next_zf  = (res == mox_pkg::BYTE_ZERO);
          end
          mox_pkg::OP_OR_STO: begin
            res           = acc | rdata;
            next_we       = 1'b1;
            next_mem.wr   = 1'b1;
            next_mem.wdata = res;
            next_zf       = (res == mox_pkg::BYTE_ZERO);
          end
          default: begin
            next_we        = 1'b1;
            next_mem.wr    = 1'b1;
            next_mem.wdata = {rdata[6:0], rdata[7]};
          end
        endcase
      end
      default: begin
        next_state = mox_pkg::ST_IDLE;
      end
    endcase
    next_busy = (next_state != mox_pkg::ST_IDLE);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= mox_pkg::ST_IDLE;
      op    <= mox_pkg::OP_IDLE;
      mem   <= '0;
      we    <= 1'b0;
      pc    <= mox_pkg::PC_RESET;
      acc   <= mox_pkg::BYTE_ZERO;
      zf    <= 1'b0;
      gie   <= 1'b0;
      done  <= 1'b0;
      irqt  <= 1'b0;
      sp    <= 4'h0;
      busy  <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        stk[i] <= mox_pkg::PC_RESET;
      end
    end else begin
      state <= next_state;
      op    <= next_op;
      mem   <= next_mem;
      we    <= next_we;
      pc    <= next_pc;
      acc   <= next_acc;
      zf    <= next_zf;
      gie   <= next_gie;
      done  <= next_done;
      irqt  <= next_irqt;
      sp    <= next_sp;
      busy  <= next_busy;
      for (int i = 0; i < 8; i++) begin
        stk[i] <= next_stk[i];
      end
    end
  end

  always_comb begin
    busy_o                    = busy;
    done_o                    = done;
    pc_o                      = pc;
    working_reg_o             = acc;
    result_null_flag_o        = zf;
    global_interrupt_enable_o = gie;
    irq_taken_o               = irqt;
  end

  //////////////////////////////////////////////////////////////////////////////

  idle_keeps_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == mox_pkg::ST_IDLE && req_valid_i && req_i.op == mox_pkg::OP_IDLE)
    |=> (acc == $past(acc) && zf == $past(zf) && pc == $past(pc) + 13'h0001))
    else $error("idle changed state");

  or_imm_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == mox_pkg::ST_IDLE && req_valid_i && req_i.op == mox_pkg::OP_OR_IMM)
    |=> (acc == ($past(acc) | $past(req_i.imm)) && zf == (acc == 8'h00)))
    else $error("or immediate wrong");

  zero_flag_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == mox_pkg::ST_WRITE && op == mox_pkg::OP_OR_MEM) |=> (zf == (acc == 8'h00)))
    else $error("zero flag wrong");

  or_store_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == mox_pkg::ST_WRITE && op == mox_pkg::OP_OR_STO)
    |=> (we && mem.wdata == ($past(acc) | $past(rdata)) && acc == $past(acc)))
    else $error("or store wrong");

  or_mem_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == mox_pkg::ST_WRITE && op == mox_pkg::OP_OR_MEM)
    |=> (acc == ($past(acc) | $past(rdata)) && !we))
    else $error("or memory wrong");

  ret_pop_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == mox_pkg::ST_IDLE && req_valid_i && !push_i && req_i.op == mox_pkg::OP_RET)
    |=> (pc == $past(top) && zf == $past(zf) && sp == $past(sp) - 4'h1))
    else $error("return pop wrong");

  ret_imm_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == mox_pkg::ST_IDLE && req_valid_i && req_i.op == mox_pkg::OP_RET_IMM)
    |=> (acc == $past(req_i.imm) && pc == $past(top)))
    else $error("return immediate wrong");

  interrupt_exit_gie_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == mox_pkg::ST_IDLE && req_valid_i && !irq_pending_i && req_i.op == mox_pkg::OP_INTERRUPT_EXIT)
    |=> (gie && pc == $past(top) && zf == $past(zf)))
    else $error("interrupt exit wrong");

  interrupt_exit_irq_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == mox_pkg::ST_IDLE && req_valid_i && irq_pending_i && req_i.op == mox_pkg::OP_INTERRUPT_EXIT)
    |=> (irqt && pc == mox_pkg::IRQ_VECT && sp == $past(sp)))
    else $error("pending interrupt skipped");

  rotate_a : assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == mox_pkg::ST_WRITE && op == mox_pkg::OP_ROL)
    |=> (we && mem.wdata == {$past(rdata[6:0]), $past(rdata[7])} && zf == $past(zf)))
    else $error("rotate wrong");

endmodule : mox_exec

/* File: tb/mox_stack_model.sv */
`timescale 1ns/1ps
// Core side that calls subroutines and keeps the expected return stack.
module mox_stack_model (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  // Bench control.
  input  wire logic        call_i,
  input  wire logic [12:0] call_pc_i,
  input  wire logic        pop_i,
  // Push to the block and expected top entry.
  output logic             push_o,
  output logic [12:0]      push_pc_o,
  output logic [12:0]      top_o
);
  logic [12:0] stk [8];
  logic [2:0]  sp;
  assign top_o = stk[sp - 3'd1];
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      push_o    <= 1'b0;
      push_pc_o <= 13'h0000;
      sp        <= 3'd0;
    end else begin
      push_o    <= call_i;
      push_pc_o <= call_pc_i;
      if (call_i) begin
        stk[sp] <= call_pc_i;
        sp      <= sp + 3'd1;
      end else if (pop_i) begin
        sp <= sp - 3'd1;
      end
    end
  end
endmodule : mox_stack_model

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
  logic              clk_i, rst_n_i, req_valid, irq_pending, call, pop, push;
  logic              busy, done, zf, gie, taken;
  logic [12:0]       call_pc, push_pc, top, pc, p;
  logic [7:0]        acc;
  mox_pkg::mox_req_t req;
  int                mismatches, checks_done, cycles;

  mox_stack_model i_model (.clk_i(clk_i), .rst_n_i(rst_n_i), .call_i(call), .call_pc_i(call_pc),
    .pop_i(pop), .push_o(push), .push_pc_o(push_pc), .top_o(top));
  mox_exec i_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_valid_i(req_valid), .req_i(req),
    .irq_pending_i(irq_pending), .push_i(push), .push_pc_i(push_pc), .busy_o(busy), .done_o(done),
    .pc_o(pc), .working_reg_o(acc), .result_null_flag_o(zf), .global_interrupt_enable_o(gie),
    .irq_taken_o(taken));

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      mismatches++;
      test_done();
    end
  end

  task test_done();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  task check(input logic [12:0] seen, input logic [12:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Offers one instruction, then waits for completion and checks its latency.
  task run(input mox_pkg::mox_op_t op, input logic [7:0] a, input logic [7:0] imm, input int lat);
    int n;
    @(posedge clk_i);
    req_valid <= 1'b1;
    req       <= '{op, a, imm};
    n = 0;
    do begin
      @(posedge clk_i);
      req_valid <= 1'b0;
      #1;
      n++;
      if (n == 1) begin
        check(13'(busy), 13'(lat > 1));
      end
    end while (done !== 1'b1 && n < 8);
    check(13'(n), 13'(lat));
  endtask : run

  task push_ret(input logic [12:0] rpc);
    @(posedge clk_i);
    call    <= 1'b1;
    call_pc <= rpc;
    @(posedge clk_i);
    call <= 1'b0;
    @(posedge clk_i);
  endtask : push_ret

  task drop();
    @(posedge clk_i);
    pop <= 1'b1;
    @(posedge clk_i);
    pop <= 1'b0;
  endtask : drop

  task t_idle();
    p = pc;
    run(mox_pkg::OP_IDLE, 8'h00, 8'h00, 1);
    check(pc, p + mox_pkg::PC_ONE);
    check(13'(acc), 13'h0000);
    check(13'({zf, gie, taken}), 13'h0000);
  endtask : t_idle

  task t_or_imm();
    run(mox_pkg::OP_OR_IMM, 8'h00, 8'h00, 1);
    check(13'({acc, zf}), 13'h0001);
    run(mox_pkg::OP_OR_IMM, 8'h00, 8'h5A, 1);
    check(13'({acc, zf}), 13'h00B4);
    run(mox_pkg::OP_OR_IMM, 8'h00, 8'hA5, 1);
    check(13'({acc, zf}), 13'h01FE);
  endtask : t_or_imm

  task t_store();
    run(mox_pkg::OP_OR_STO, 8'h33, 8'h00, 3);
    check(13'({acc, zf}), 13'h01FE);
    push_ret(13'h0123);
    run(mox_pkg::OP_RET_IMM, 8'h00, 8'h00, 1);
    check(pc, top);
    check(13'({acc, zf}), 13'h0000);
    drop();
    run(mox_pkg::OP_OR_MEM, 8'h33, 8'h00, 3);
    check(13'({acc, zf}), 13'h01FE);
  endtask : t_store

  // Builds a lopsided byte in memory so that a wrong rotate shows up.
  task t_rotate();
    push_ret(13'h0040);
    run(mox_pkg::OP_RET_IMM, 8'h00, 8'h96, 1);
    drop();
    run(mox_pkg::OP_OR_STO, 8'h44, 8'h00, 3);
    check(13'({acc, zf}), 13'h012C);
    push_ret(13'h0041);
    run(mox_pkg::OP_RET_IMM, 8'h00, 8'h00, 1);
    drop();
    run(mox_pkg::OP_OR_IMM, 8'h00, 8'h00, 1);
    p = pc;
    run(mox_pkg::OP_ROL, 8'h44, 8'h00, 3);
    check(13'({acc, zf}), 13'h0001);
    check(pc, p + mox_pkg::PC_ONE);
    run(mox_pkg::OP_OR_MEM, 8'h44, 8'h00, 3);
    check(13'({acc, zf}), 13'h005A);
  endtask : t_rotate

  task t_returns();
    push_ret(13'h00AB);
    run(mox_pkg::OP_RET, 8'h00, 8'h00, 1);
    check(pc, top);
    check(13'({acc, zf}), 13'h005A);
    drop();
    push_ret(13'h01C0);
    run(mox_pkg::OP_INTERRUPT_EXIT, 8'h00, 8'h00, 1);
    check(pc, top);
    check(13'({gie, taken, zf}), 13'h0004);
    drop();
    push_ret(13'h0155);
    irq_pending <= 1'b1;
    run(mox_pkg::OP_INTERRUPT_EXIT, 8'h00, 8'h00, 1);
    check(pc, mox_pkg::IRQ_VECT);
    check(13'(taken), 13'h0001);
    @(posedge clk_i);
    irq_pending <= 1'b0;
    run(mox_pkg::OP_RET, 8'h00, 8'h00, 1);
    check(pc, 13'h0155);
    drop();
  endtask : t_returns

  initial begin
    {rst_n_i, req_valid, irq_pending, call, pop} = 5'h00;
    call_pc     = 13'h0000;
    req         = '{mox_pkg::OP_IDLE, 8'h00, 8'h00};
    mismatches  = 0;
    checks_done = 0;
    cycles      = 0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_idle();
    t_or_imm();
    t_store();
    t_rotate();
    t_returns();
    test_done();
  end
endmodule : tb
